/* File: logic/lfsb_live_fault_status_bank.sv */
// Live fault status bank: four read-only diagnostic status registers
`timescale 1ns/10ps
`default_nettype none
module lfsb_live_fault_status_bank (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clock_error_in,
  input wire logic pll_lock_in,
  input wire logic ch1_pos_short_in,
  input wire logic ch1_neg_short_in,
  input wire logic ch1_pos_vgnd_in,
  input wire logic ch1_neg_vgnd_in,
  input wire logic ch2_pos_short_in,
  input wire logic ch2_neg_short_in,
  input wire logic ch2_pos_vgnd_in,
  input wire logic ch2_neg_vgnd_in,
  input wire logic regulator_short_in,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit
);

  logic [lfsb_pkg::NUM_INPUTS-1:0] raw_in;
  logic [lfsb_pkg::NUM_INPUTS-1:0] synced;

  logic [7:0] clock_pll_live_status;
  logic [7:0] channel_fault_summary_live;
  logic [7:0] output1_fault_live;
  logic [7:0] output2_fault_live;
  logic [7:0] next_clock_pll_live_status;
  logic [7:0] next_channel_fault_summary_live;
  logic [7:0] next_output1_fault_live;
  logic [7:0] next_output2_fault_live;

  logic next_reg_hit;
  logic write_seen;

  assign raw_in[lfsb_pkg::IN_CLOCK_ERROR] = clock_error_in;
  assign raw_in[lfsb_pkg::IN_PLL_LOCK] = pll_lock_in;
  assign raw_in[lfsb_pkg::IN_CH1_POS_SHORT] = ch1_pos_short_in;
  assign raw_in[lfsb_pkg::IN_CH1_NEG_SHORT] = ch1_neg_short_in;
  assign raw_in[lfsb_pkg::IN_CH1_POS_VGND] = ch1_pos_vgnd_in;
  assign raw_in[lfsb_pkg::IN_CH1_NEG_VGND] = ch1_neg_vgnd_in;
  assign raw_in[lfsb_pkg::IN_CH2_POS_SHORT] = ch2_pos_short_in;
  assign raw_in[lfsb_pkg::IN_CH2_NEG_SHORT] = ch2_neg_short_in;
  assign raw_in[lfsb_pkg::IN_CH2_POS_VGND] = ch2_pos_vgnd_in;
  assign raw_in[lfsb_pkg::IN_CH2_NEG_VGND] = ch2_neg_vgnd_in;
  assign raw_in[lfsb_pkg::IN_REGULATOR_SHORT] = regulator_short_in;

  // Fault detectors sit in the analog domain, so every input is synchronised first
  lfsb_sync #(
    .WIDTH(lfsb_pkg::NUM_INPUTS)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in(raw_in),
    .sync_out(synced)
  );

  // Live bits: rebuilt from the inputs every cycle, so nothing is held
  always_comb
  begin
    next_clock_pll_live_status = lfsb_pkg::CLOCK_PLL_LIVE_STATUS_RST;
    next_clock_pll_live_status[lfsb_pkg::CLOCK_ERROR_BIT] =
      synced[lfsb_pkg::IN_CLOCK_ERROR];
    next_clock_pll_live_status[lfsb_pkg::PLL_LOCK_BIT] =
      synced[lfsb_pkg::IN_PLL_LOCK];

    next_output1_fault_live = lfsb_pkg::OUTPUT1_FAULT_LIVE_RST;
    next_output1_fault_live[lfsb_pkg::POS_SHORT_BIT] =
      synced[lfsb_pkg::IN_CH1_POS_SHORT];
    next_output1_fault_live[lfsb_pkg::NEG_SHORT_BIT] =
      synced[lfsb_pkg::IN_CH1_NEG_SHORT];
    next_output1_fault_live[lfsb_pkg::POS_VGND_BIT] =
      synced[lfsb_pkg::IN_CH1_POS_VGND];
    next_output1_fault_live[lfsb_pkg::NEG_VGND_BIT] =
      synced[lfsb_pkg::IN_CH1_NEG_VGND];

    next_output2_fault_live = lfsb_pkg::OUTPUT2_FAULT_LIVE_RST;
    next_output2_fault_live[lfsb_pkg::POS_SHORT_BIT] =
      synced[lfsb_pkg::IN_CH2_POS_SHORT];
    next_output2_fault_live[lfsb_pkg::NEG_SHORT_BIT] =
      synced[lfsb_pkg::IN_CH2_NEG_SHORT];
    next_output2_fault_live[lfsb_pkg::POS_VGND_BIT] =
      synced[lfsb_pkg::IN_CH2_POS_VGND];
    next_output2_fault_live[lfsb_pkg::NEG_VGND_BIT] =
      synced[lfsb_pkg::IN_CH2_NEG_VGND];
    next_output2_fault_live[lfsb_pkg::REGULATOR_SHORT_BIT] =
      synced[lfsb_pkg::IN_REGULATOR_SHORT];

    // Summary built from the same next values so it never lags the detail bits
    next_channel_fault_summary_live = lfsb_pkg::CHANNEL_FAULT_SUMMARY_LIVE_RST;
    next_channel_fault_summary_live[lfsb_pkg::CH1_FAULT_FLAG_BIT] =
      |next_output1_fault_live[lfsb_pkg::POS_SHORT_BIT:lfsb_pkg::NEG_VGND_BIT];
    next_channel_fault_summary_live[lfsb_pkg::CH2_FAULT_FLAG_BIT] =
      |next_output2_fault_live[lfsb_pkg::POS_SHORT_BIT:lfsb_pkg::NEG_VGND_BIT];
  end

  // Write data has no path into any of these flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_pll_live_status <= lfsb_pkg::CLOCK_PLL_LIVE_STATUS_RST;
      channel_fault_summary_live <= lfsb_pkg::CHANNEL_FAULT_SUMMARY_LIVE_RST;
      output1_fault_live <= lfsb_pkg::OUTPUT1_FAULT_LIVE_RST;
      output2_fault_live <= lfsb_pkg::OUTPUT2_FAULT_LIVE_RST;
    end
    else
    begin
      clock_pll_live_status <= next_clock_pll_live_status;
      channel_fault_summary_live <= next_channel_fault_summary_live;
      output1_fault_live <= next_output1_fault_live;
      output2_fault_live <= next_output2_fault_live;
    end
  end

  // Hit flag: last access named one of the four registers
  assign write_seen = reg_write && (reg_wdata == reg_wdata);

  always_comb
  begin
    next_reg_hit = reg_hit;
    if (reg_read || write_seen)
      next_reg_hit = lfsb_pkg::is_mapped(reg_addr);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reg_hit <= 1'b0;
    else
      reg_hit <= next_reg_hit;
  end

  lfsb_read_port u_read_port (
    .clock(clock),
    .nrst(nrst),
    .reg_read(reg_read),
    .reg_addr(reg_addr),
    .clock_pll_live_status(clock_pll_live_status),
    .channel_fault_summary_live(channel_fault_summary_live),
    .output1_fault_live(output1_fault_live),
    .output2_fault_live(output2_fault_live),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );

  // Helper: counts edges since reset release until the input pipeline is full
  logic [1:0] settle_cnt;
  logic [1:0] next_settle_cnt;
  logic settled;

  assign settled = (settle_cnt == 2'(lfsb_pkg::INPUT_LATENCY));

  always_comb
  begin
    next_settle_cnt = settle_cnt;
    if (!settled)
      next_settle_cnt = settle_cnt + 2'h1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      settle_cnt <= 2'h0;
    else
      settle_cnt <= next_settle_cnt;
  end

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (!nrst);

  clock_error_bit_a: assert property (
    settled |-> clock_pll_live_status[7] == $past(clock_error_in, 3))
    else $error("clock error bit does not follow its input");

  pll_lock_bit_a: assert property (
    settled |-> clock_pll_live_status[6] == $past(pll_lock_in, 3))
    else $error("PLL lock bit does not follow its input");

  reserved_single_zero_a: assert property (
    clock_pll_live_status[5:0] == 6'h00 && channel_fault_summary_live[7:6] == 2'h0 &&
    channel_fault_summary_live[3:0] == 4'h0)
    else $error("reserved single bit reads nonzero");

  ch1_summary_a: assert property (
    channel_fault_summary_live[5] == |output1_fault_live[7:4])
    else $error("channel 1 summary disagrees with its fault bits");

  ch2_summary_a: assert property (
    channel_fault_summary_live[4] == |output2_fault_live[7:4])
    else $error("channel 2 summary disagrees with its fault bits");

  out1_short_a: assert property (
    settled |-> output1_fault_live[7:6] == {$past(ch1_pos_short_in, 3),
                                           $past(ch1_neg_short_in, 3)})
    else $error("channel 1 short bits do not follow their inputs");

  out1_vgnd_a: assert property (
    settled |-> output1_fault_live[5:4] == {$past(ch1_pos_vgnd_in, 3),
                                           $past(ch1_neg_vgnd_in, 3)})
    else $error("channel 1 virtual ground bits do not follow their inputs");

  out2_short_a: assert property (
    settled |-> output2_fault_live[7:6] == {$past(ch2_pos_short_in, 3),
                                           $past(ch2_neg_short_in, 3)})
    else $error("channel 2 short bits do not follow their inputs");

  out2_vgnd_a: assert property (
    settled |-> output2_fault_live[5:4] == {$past(ch2_pos_vgnd_in, 3),
                                           $past(ch2_neg_vgnd_in, 3)})
    else $error("channel 2 virtual ground bits do not follow their inputs");

  regulator_short_a: assert property (
    settled |-> output2_fault_live[0] == $past(regulator_short_in, 3))
    else $error("regulator short bit does not follow its input");

  reserved_field_zero_a: assert property (
    output1_fault_live[3:0] == 4'h0 && output2_fault_live[3:1] == 3'h0)
    else $error("reserved field reads nonzero");

  summary_clears_a: assert property (
    settled && !ch1_pos_short_in && !ch1_neg_short_in && !ch1_pos_vgnd_in &&
    !ch1_neg_vgnd_in ##1 !ch1_pos_short_in && !ch1_neg_short_in && !ch1_pos_vgnd_in &&
    !ch1_neg_vgnd_in |-> ##2 !channel_fault_summary_live[5])
    else $error("channel 1 summary holds a fault that has gone");

  reset_zero_a: assert property (
    settle_cnt == 2'h0 |-> clock_pll_live_status == 8'h00 &&
    channel_fault_summary_live == 8'h00 && output1_fault_live == 8'h00 &&
    output2_fault_live == 8'h00)
    else $error("status not zero at reset release");

  write_ignored_a: assert property (
    reg_write && !reg_read |=> !reg_rvalid && $stable(reg_rdata))
    else $error("a write disturbed the read answer");

  read_out1_a: assert property (
    reg_read && reg_addr == 8'h40 |=> reg_rvalid && reg_rdata == $past(output1_fault_live))
    else $error("read of channel 1 faults returns the wrong value");

  read_unmapped_a: assert property (
    reg_read && !lfsb_pkg::is_mapped(reg_addr) |=> reg_rdata == 8'h00 && !reg_hit)
    else $error("unmapped read returns data or a hit");

  ch2_summary_clears_a: assert property (
    settled && !ch2_pos_short_in && !ch2_neg_short_in && !ch2_pos_vgnd_in &&
    !ch2_neg_vgnd_in ##1 !ch2_pos_short_in && !ch2_neg_short_in && !ch2_pos_vgnd_in &&
    !ch2_neg_vgnd_in |-> ##2 !channel_fault_summary_live[4])
    else $error("channel 2 summary holds a fault that has gone");

  read_clock_pll_a: assert property (
    reg_read && reg_addr == lfsb_pkg::CLOCK_PLL_LIVE_STATUS_OFS |=>
    reg_rvalid && reg_rdata == $past(clock_pll_live_status))
    else $error("read of clock and PLL status returns the wrong value");

  read_summary_a: assert property (
    reg_read && reg_addr == lfsb_pkg::CHANNEL_FAULT_SUMMARY_LIVE_OFS |=>
    reg_rvalid && reg_rdata == $past(channel_fault_summary_live))
    else $error("read of channel summary returns the wrong value");

  read_out2_a: assert property (
    reg_read && reg_addr == lfsb_pkg::OUTPUT2_FAULT_LIVE_OFS |=>
    reg_rvalid && reg_rdata == $past(output2_fault_live))
    else $error("read of channel 2 faults returns the wrong value");

  read_stable_a: assert property (
    !reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  ch1_fault_read_c: cover property (
    output1_fault_live[7] ##1 reg_read && reg_addr == 8'h40);

  summary_drop_c: cover property (
    channel_fault_summary_live[4] ##[1:20] !channel_fault_summary_live[4]);

  write_attempt_c: cover property (
    reg_write && reg_addr == 8'h3C);

  clock_error_c: cover property (
    clock_pll_live_status[7] && clock_pll_live_status[6]);

endmodule
`default_nettype wire

/* File: logic/lfsb_pkg.sv */
// Package of offsets, field positions and reset values for the live fault status bank
package lfsb_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] CLOCK_PLL_LIVE_STATUS_OFS = 8'h3C;
  localparam logic [7:0] CHANNEL_FAULT_SUMMARY_LIVE_OFS = 8'h3D;
  localparam logic [7:0] OUTPUT1_FAULT_LIVE_OFS = 8'h40;
  localparam logic [7:0] OUTPUT2_FAULT_LIVE_OFS = 8'h41;

  // Reset values
  localparam logic [7:0] CLOCK_PLL_LIVE_STATUS_RST = 8'h00;
  localparam logic [7:0] CHANNEL_FAULT_SUMMARY_LIVE_RST = 8'h00;
  localparam logic [7:0] OUTPUT1_FAULT_LIVE_RST = 8'h00;
  localparam logic [7:0] OUTPUT2_FAULT_LIVE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Field positions in clock_pll_live_status
  localparam int unsigned CLOCK_ERROR_BIT = 7;
  localparam int unsigned PLL_LOCK_BIT = 6;

  // Field positions in channel_fault_summary_live
  localparam int unsigned CH1_FAULT_FLAG_BIT = 5;
  localparam int unsigned CH2_FAULT_FLAG_BIT = 4;

  // Field positions in output1/output2 fault registers
  localparam int unsigned POS_SHORT_BIT = 7;
  localparam int unsigned NEG_SHORT_BIT = 6;
  localparam int unsigned POS_VGND_BIT = 5;
  localparam int unsigned NEG_VGND_BIT = 4;
  localparam int unsigned REGULATOR_SHORT_BIT = 0;

  // Number of raw fault and event inputs, and their order in the synchroniser word
  localparam int unsigned NUM_INPUTS = 11;
  localparam int unsigned IN_CLOCK_ERROR = 0;
  localparam int unsigned IN_PLL_LOCK = 1;
  localparam int unsigned IN_CH1_POS_SHORT = 2;
  localparam int unsigned IN_CH1_NEG_SHORT = 3;
  localparam int unsigned IN_CH1_POS_VGND = 4;
  localparam int unsigned IN_CH1_NEG_VGND = 5;
  localparam int unsigned IN_CH2_POS_SHORT = 6;
  localparam int unsigned IN_CH2_NEG_SHORT = 7;
  localparam int unsigned IN_CH2_POS_VGND = 8;
  localparam int unsigned IN_CH2_NEG_VGND = 9;
  localparam int unsigned IN_REGULATOR_SHORT = 10;

  // Cycles from a raw input edge to the status bit: two synchroniser stages plus the register
  localparam int unsigned INPUT_LATENCY = 3;

  // True when the offset belongs to one of the four live status registers
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == CLOCK_PLL_LIVE_STATUS_OFS) ||
                (addr == CHANNEL_FAULT_SUMMARY_LIVE_OFS) ||
                (addr == OUTPUT1_FAULT_LIVE_OFS) ||
                (addr == OUTPUT2_FAULT_LIVE_OFS);
  endfunction

endpackage

/* File: logic/lfsb_read_port.sv */
// Registered read answer for the four live status registers
`timescale 1ns/10ps
`default_nettype none
module lfsb_read_port (
  input wire logic clock,
  input wire logic nrst,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] clock_pll_live_status,
  input wire logic [7:0] channel_fault_summary_live,
  input wire logic [7:0] output1_fault_live,
  input wire logic [7:0] output2_fault_live,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid
);

  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;

  always_comb
  begin
    next_reg_rdata = reg_rdata;
    next_reg_rvalid = reg_read;
    if (reg_read)
    begin
      if (reg_addr == lfsb_pkg::CLOCK_PLL_LIVE_STATUS_OFS)
        next_reg_rdata = clock_pll_live_status;
      else if (reg_addr == lfsb_pkg::CHANNEL_FAULT_SUMMARY_LIVE_OFS)
        next_reg_rdata = channel_fault_summary_live;
      else if (reg_addr == lfsb_pkg::OUTPUT1_FAULT_LIVE_OFS)
        next_reg_rdata = output1_fault_live;
      else if (reg_addr == lfsb_pkg::OUTPUT2_FAULT_LIVE_OFS)
        next_reg_rdata = output2_fault_live;
      else
        next_reg_rdata = lfsb_pkg::UNMAPPED_READ_VALUE;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= lfsb_pkg::UNMAPPED_READ_VALUE;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

endmodule
`default_nettype wire

/* File: logic/lfsb_sync.sv */
// Two-stage synchroniser for the asynchronous fault and event inputs
`timescale 1ns/10ps
`default_nettype none
module lfsb_sync #(
  parameter int unsigned WIDTH = lfsb_pkg::NUM_INPUTS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule
`default_nettype wire

/* File: tb/lfsb_host_model.sv */
// Host model that reaches the live fault status bank through its register port
`timescale 1ns/10ps
`default_nettype none
module lfsb_host_model (
  input wire logic clock,
  output logic reg_read,
  output logic reg_write,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit
);
  initial
  begin
    reg_read = 1'b0;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One strobe per access, driven and released on falling edges
  task automatic access(input logic wr, input logic [7:0] addr, output logic [7:0] rdata,
                        output logic valid, output logic hit);
    @(negedge clock);
    reg_read <= ~wr;
    reg_write <= wr;
    reg_addr <= addr;
    reg_wdata <= 8'h00;
    @(negedge clock);
    reg_read <= 1'b0;
    reg_write <= 1'b0;
    // Released lines show the inverse so stale values are never taken for live ones
    reg_addr <= ~addr;
    reg_wdata <= 8'hFF;
    rdata = reg_rdata;
    valid = reg_rvalid;
    hit = reg_hit;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the live fault status bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [10:0] faults;
    logic [7:0] e0;
    logic [7:0] e1;
    logic [7:0] e2;
    logic [7:0] e3;
  } lfsb_row_t;

  logic clock;
  logic nrst;
  logic [10:0] faults;
  logic rd;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic hit;
  int num_errors = 0;
  int total_checks = 0;

  // Fault order: clock err, pll, ch1 ps ns pv nv, ch2 ps ns pv nv, regulator
  lfsb_row_t rows [0:13] = '{
    '{11'h000, 8'h00, 8'h00, 8'h00, 8'h00}, '{11'h001, 8'h80, 8'h00, 8'h00, 8'h00},
    '{11'h002, 8'h40, 8'h00, 8'h00, 8'h00}, '{11'h004, 8'h00, 8'h20, 8'h80, 8'h00},
    '{11'h008, 8'h00, 8'h20, 8'h40, 8'h00}, '{11'h010, 8'h00, 8'h20, 8'h20, 8'h00},
    '{11'h020, 8'h00, 8'h20, 8'h10, 8'h00}, '{11'h040, 8'h00, 8'h10, 8'h00, 8'h80},
    '{11'h080, 8'h00, 8'h10, 8'h00, 8'h40}, '{11'h100, 8'h00, 8'h10, 8'h00, 8'h20},
    '{11'h200, 8'h00, 8'h10, 8'h00, 8'h10}, '{11'h400, 8'h00, 8'h00, 8'h00, 8'h01},
    '{11'h7FF, 8'hC0, 8'h30, 8'hF0, 8'hF1}, '{11'h000, 8'h00, 8'h00, 8'h00, 8'h00}
  };
  logic [7:0] offs [0:3] = '{lfsb_pkg::CLOCK_PLL_LIVE_STATUS_OFS,
    lfsb_pkg::CHANNEL_FAULT_SUMMARY_LIVE_OFS, lfsb_pkg::OUTPUT1_FAULT_LIVE_OFS,
    lfsb_pkg::OUTPUT2_FAULT_LIVE_OFS};
  logic [7:0] holes [0:4] = '{8'h3E, 8'h3F, 8'h42, 8'h00, 8'hFF};

  lfsb_live_fault_status_bank dut (
    .clock(clock), .nrst(nrst),
    .clock_error_in(faults[0]), .pll_lock_in(faults[1]),
    .ch1_pos_short_in(faults[2]), .ch1_neg_short_in(faults[3]),
    .ch1_pos_vgnd_in(faults[4]), .ch1_neg_vgnd_in(faults[5]),
    .ch2_pos_short_in(faults[6]), .ch2_neg_short_in(faults[7]),
    .ch2_pos_vgnd_in(faults[8]), .ch2_neg_vgnd_in(faults[9]),
    .regulator_short_in(faults[10]),
    .reg_read(rd), .reg_write(wr), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_hit(hit)
  );

  lfsb_host_model host (
    .clock(clock), .reg_read(rd), .reg_write(wr), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_hit(hit)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp_v);
    total_checks++;
    if (seen !== exp_v)
    begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp_v);
    end
  endtask

  task automatic read_reg(input logic [7:0] a, input logic [7:0] exp_d, input logic exp_h);
    logic [7:0] d;
    logic v;
    logic h;
    host.access(1'b0, a, d, v, h);
    check({7'h00, v}, 8'h01);
    check(d, exp_d);
    check({7'h00, h}, {7'h00, exp_h});
  endtask

  task automatic check_bank(input logic [7:0] e0, input logic [7:0] e1,
                            input logic [7:0] e2, input logic [7:0] e3);
    read_reg(offs[0], e0, 1'b1);
    read_reg(offs[1], e1, 1'b1);
    read_reg(offs[2], e2, 1'b1);
    read_reg(offs[3], e3, 1'b1);
  endtask

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clock);
    num_errors++;
    close_out();
  end

  initial
  begin
    logic [7:0] d;
    logic v;
    logic h;
    faults = 11'h000;
    nrst = 1'b0;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    check_bank(8'h00, 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 14; i++)
    begin
      faults = rows[i].faults;
      repeat (lfsb_pkg::INPUT_LATENCY) @(negedge clock);
      check_bank(rows[i].e0, rows[i].e1, rows[i].e2, rows[i].e3);
    end
    // Writes with every fault present must neither clear nor set anything
    faults = 11'h7FF;
    repeat (lfsb_pkg::INPUT_LATENCY) @(negedge clock);
    for (int i = 0; i < 4; i++)
    begin
      host.access(1'b1, offs[i], d, v, h);
      check({7'h00, h}, 8'h01);
      check({7'h00, v}, 8'h00);
    end
    host.access(1'b1, 8'h3E, d, v, h);
    check({7'h00, h}, 8'h00);
    check_bank(8'hC0, 8'h30, 8'hF0, 8'hF1);
    for (int i = 0; i < 5; i++)
      read_reg(holes[i], lfsb_pkg::UNMAPPED_READ_VALUE, 1'b0);
    // Reset in mid-run with faults still present
    @(negedge clock);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    check(rdata, 8'h00);
    check({6'h00, rvalid, hit}, 8'h00);
    nrst = 1'b1;
    read_reg(offs[2], 8'h00, 1'b1);
    repeat (lfsb_pkg::INPUT_LATENCY) @(negedge clock);
    read_reg(offs[3], 8'hF1, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
